// ---- rtl/pfc_regs.sv ----
// fiber control register bank of an ethernet transceiver
// Operation
// [RULE_01] 16-bit receive error counter counts each error, pegs at all ones.
// [RULE_02] false carrier and symbol errors both increment the counter.
// [RULE_03] reading the counter returns its value and clears it.
// [RULE_04] 8-bit page field, any page, zero on hard reset, kept on soft.
// [RULE_05] global interrupt bit 0 shows an active interrupt; other bits zero.
// [RULE_06] fiber reset bit resets fiber logic at once and self-clears.
// [RULE_07] loopback returns transmit data to receive and breaks the link.
// [RULE_08] loopback runs at 1000 Mbps in 1000X mode, 100 in 100FX.
// [RULE_09] speed bits: mode 00 forces 01, mode 01 forces 10.
// [RULE_10] mode 10 shows negotiated speed; mode 11 makes speed writable.
// [RULE_11] changing negotiation enable breaks link and sets the restart bit.
// [RULE_12] negotiation enable has no effect in 100FX mode.
// [RULE_13] negotiation enable loads the strap on hard reset, kept on soft.
// [RULE_14] leaving power down performs soft reset and negotiation restart.
// [RULE_15] restart after hard reset, soft reset, enable change, or bit write.
// [RULE_16] duplex write applies only on reset, restart, enable change, wake.
// [RULE_17] isolate and collision test read zero and ignore writes.
`timescale 1ns/1ps
module pfc_regs
  import pfc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        false_carrier_i,
  input  wire logic        symbol_err_i,
  input  wire logic [1:0]  fiber_mode_i,
  input  wire logic        neg_speed_1000_i,
  input  wire logic        strap_autoneg_default_i,
  output logic             fiber_reset_o,
  output logic             loopback_o,
  output logic             loop_rate_1000_o,
  output logic             link_break_o,
  output logic [1:0]       speed_o,
  output logic             autoneg_en_o,
  output logic             an_restart_o,
  output logic             power_down_o,
  output logic             duplex_full_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [1:0]  strap_s;    // strap synchroniser, [1] is the safe copy
    logic [1:0]  init_cnt;
    logic        init_done;
    logic        loop;
    logic [1:0]  spd_w;      // software speed, used in mode 11
    logic        an_en;
    logic        pdown;
    logic        restart;    // restart bit, pending until executed
    logic        duplex_w;   // written duplex, not yet in force
    logic        duplex_act; // duplex in force
    logic [7:0]  page;
    logic [3:0]  rst_cnt;
    logic        rst_busy;
    logic        an_pulse;
    logic        link_break;
    logic [15:0] rdata;
    logic [1:0]  speed;
    logic        loop_1000;
    logic        an_eff;
  } pfc_top_s;

  pfc_top_s q;
  pfc_top_s d;

  pfc_ev_if evb ();

  // strobes decoded from the management port, plus the reset-done strobe and the 100FX flag
  logic fc_wr;
  logic fc_rd;
  logic en_chg;
  logic pd_wake;
  logic sw_rst;
  logic rst_done;
  logic fx_mode;

  assign fx_mode  = (fiber_mode_i == MODE_100FX);
  assign fc_wr    = wr_i && (addr_i == REG_FIBER_CTRL)
                    && (q.page == PAGE_FIBER);
  assign fc_rd    = rd_i && (addr_i == REG_FIBER_CTRL)
                    && (q.page == PAGE_FIBER);
  // an enable toggle is ignored in 100FX mode
  assign en_chg   = fc_wr && (wdata_i[FC_AN_EN] != q.an_en)
                    && !fx_mode;                       // see [RULE_12]
  assign pd_wake  = fc_wr && q.pdown && !wdata_i[FC_PDOWN]; // see [RULE_14]
  assign sw_rst   = fc_wr && (wdata_i[FC_RESET] || pd_wake); // see [RULE_06]
  assign rst_done = q.rst_busy && (q.rst_cnt == 4'h1);

  // hooks to the counter and the interrupt helper
  assign evb.false_carrier = false_carrier_i;
  assign evb.symbol_err    = symbol_err_i;
  assign evb.cnt_clr       = rd_i && (addr_i == REG_RXERR)
                             && (q.page == PAGE_COPPER); // see [RULE_03]
  assign evb.irq_clr_wr    = wr_i && (addr_i == REG_IRQ_CLR);
  assign evb.irq_en_wr     = wr_i && (addr_i == REG_IRQ_EN);
  assign evb.irq_wdata     = wdata_i[EV_W-1:0];

  // interrupt sources; the error strobe stays high while errors keep arriving, the others are one-cycle pulses
  always_comb begin
    evb.ev             = '0;
    evb.ev[EV_RXERR]   = evb.cnt_inc;
    evb.ev[EV_SAT]     = evb.cnt_sat;
    evb.ev[EV_ANRST]   = q.an_pulse;
    evb.ev[EV_RSTDONE] = rst_done;
  end

  pfc_rxerr_cnt u_cnt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ev       (evb.cnt_side)
  );

  pfc_irq u_irq (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ev       (evb.irq_side)
  );

  // next state; later assignments win, so restart sets follow its clear and soft reset follows writes
  always_comb begin
    d            = q;
    d.strap_s    = {q.strap_s[0], strap_autoneg_default_i};
    d.an_pulse   = 1'b0;

    // pending restart runs once no reset is in progress
    if (q.restart && !q.rst_busy) begin
      d.restart    = 1'b0;
      d.an_pulse   = 1'b1;                             // see [RULE_15]
      d.duplex_act = q.duplex_w;                       // see [RULE_16]
    end

    // soft reset counts down, then asks for a restart
    if (q.rst_busy) begin
      d.rst_cnt = q.rst_cnt - 4'h1;
      if (rst_done) begin
        d.rst_busy = 1'b0;                             // see [RULE_06]
        d.restart  = 1'b1;                             // see [RULE_15]
      end
    end

    // page select is reachable from every page
    if (wr_i && (addr_i == REG_PAGE)) begin
      d.page = wdata_i[7:0];                           // see [RULE_04]
    end

    // fiber control writes; isolate and collision test are dropped
    if (fc_wr) begin
      d.loop     = wdata_i[FC_LOOP];
      d.an_en    = wdata_i[FC_AN_EN];
      d.pdown    = wdata_i[FC_PDOWN];
      d.duplex_w = wdata_i[FC_DUPLEX];                 // see [RULE_16]
      if (fiber_mode_i == MODE_SW) begin
        d.spd_w = {wdata_i[FC_SPD_MSB],
                   wdata_i[FC_SPD_LSB]};               // see [RULE_10]
      end
      if (wdata_i[FC_RESTART] || en_chg || pd_wake) begin
        d.restart = 1'b1;                              // see [RULE_11]
      end
    end

    // soft reset clears loopback and power down, keeps the rest
    if (sw_rst) begin
      d.rst_busy = 1'b1;                               // see [RULE_14]
      d.rst_cnt  = FRST_CYCLES;
      d.loop     = 1'b0;
      d.pdown    = 1'b0;
    end

    // strap is only trusted after the synchroniser has filled
    if (!q.init_done) begin
      d.init_cnt = q.init_cnt + 2'h1;
      if (q.init_cnt == STRAP_WAIT) begin
        d.an_en     = q.strap_s[1];                    // see [RULE_13]
        d.init_done = 1'b1;
        d.restart   = 1'b1;                            // see [RULE_15]
      end
    end

    // speed field follows the fiber mode
    case (fiber_mode_i)
      MODE_100FX: d.speed = SPD_100;                   // see [RULE_09]
      MODE_1000X: d.speed = SPD_1000;                  // see [RULE_09]
      MODE_NEG:   d.speed = neg_speed_1000_i ? SPD_1000
                                             : SPD_100; // see [RULE_10]
      MODE_SW:    d.speed = q.spd_w;
      default:    d.speed = SPD_1000;
    endcase

    // loopback rate tracks the mode, else the speed in force
    case (fiber_mode_i)
      MODE_100FX: d.loop_1000 = 1'b0;                  // see [RULE_08]
      MODE_1000X: d.loop_1000 = 1'b1;                  // see [RULE_08]
      default:    d.loop_1000 = (q.speed == SPD_1000);
    endcase

    // link drops in loopback, during reset and across a restart
    d.link_break = q.loop || q.rst_busy || q.restart; // see [RULE_07]
    d.an_eff     = q.an_en && !fx_mode;                // see [RULE_12]

    // read data stand for exactly one cycle after the strobe
    d.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        REG_FIBER_CTRL: begin
          if (q.page == PAGE_FIBER) begin
            d.rdata = {q.rst_busy, q.loop, q.speed[0], q.an_en,
                       q.pdown, 1'b0, q.restart, q.duplex_w,
                       1'b0, q.speed[1], 6'h00};       // see [RULE_17]
          end
        end
        REG_RXERR: begin
          if (q.page == PAGE_COPPER) begin
            d.rdata = evb.cnt;                         // see [RULE_03]
          end
        end
        REG_PAGE:     d.rdata = {8'h00, q.page};       // see [RULE_04]
        REG_GINT: begin
          if (q.page == PAGE_COPPER) begin
            d.rdata = {15'h0000, evb.irq};             // see [RULE_05]
          end
        end
        REG_IRQ_STAT: d.rdata = {12'h000, evb.irq_status};
        REG_IRQ_EN:   d.rdata = {12'h000, evb.irq_enable};
        default:      d.rdata = 16'h0000;              // unmapped reads zero
      endcase
    end
  end

  // state register; the strap is never sampled under reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q            <= '0;
      q.spd_w      <= SPD_RST;
      q.speed      <= SPD_RST;
      q.duplex_w   <= DUPLEX_RST;
      q.duplex_act <= DUPLEX_RST;
      q.page       <= PAGE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o          = q.rdata;
  assign fiber_reset_o    = q.rst_busy;
  assign loopback_o       = q.loop;
  assign loop_rate_1000_o = q.loop_1000;
  assign link_break_o     = q.link_break;
  assign speed_o          = q.speed;
  assign autoneg_en_o     = q.an_eff;
  assign an_restart_o     = q.an_pulse;
  assign power_down_o     = q.pdown;
  assign duplex_full_o    = q.duplex_act;
  assign irq_o            = evb.irq;

  // checks on what the bank drives
  a_page_upper_zero: assert property ( // see [RULE_04]
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == REG_PAGE) |=> (rdata_o == {8'h00, $past(q.page)}))
    else $error("page read wrong");

  a_gint_reflects_irq: assert property ( // see [RULE_05]
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == REG_GINT && q.page == PAGE_COPPER)
    |=> (rdata_o == {15'h0000, $past(irq_o)}))
    else $error("global interrupt bit wrong");

  a_reset_selfclear: assert property ( // see [RULE_06]
    @(posedge clk_i) disable iff (!resetn_i)
    (sw_rst && !q.rst_busy) |=> fiber_reset_o [*8] ##1 !fiber_reset_o)
    else $error("fiber reset did not self clear after 8 cycles");

  a_loop_breaks_link: assert property ( // see [RULE_07]
    @(posedge clk_i) disable iff (!resetn_i)
    (loopback_o && $past(loopback_o)) |-> link_break_o)
    else $error("link kept during loopback");

  // mode outputs still hold reset values at the release edge
  a_loop_rate_mode: assert property ( // see [RULE_08]
    @(posedge clk_i) disable iff (!resetn_i)
    ($past(resetn_i) && $past(fiber_mode_i) == MODE_1000X)
    |-> loop_rate_1000_o)
    else $error("loopback rate not 1000 in 1000X mode");

  a_speed_forced_fx: assert property ( // see [RULE_09]
    @(posedge clk_i) disable iff (!resetn_i)
    ($past(resetn_i) && $past(fiber_mode_i) == MODE_100FX)
    |-> (speed_o == SPD_100))
    else $error("speed not forced in 100FX mode");

  a_speed_forced_x: assert property ( // see [RULE_09]
    @(posedge clk_i) disable iff (!resetn_i)
    ($past(fiber_mode_i) == MODE_1000X) |-> (speed_o == SPD_1000))
    else $error("speed not forced in 1000X mode");

  a_speed_follows_neg: assert property ( // see [RULE_10]
    @(posedge clk_i) disable iff (!resetn_i)
    ($past(resetn_i) && $past(fiber_mode_i) == MODE_NEG)
    |-> (speed_o == ($past(neg_speed_1000_i) ? SPD_1000 : SPD_100)))
    else $error("speed not following negotiation");

  a_en_change_restart: assert property ( // see [RULE_11]
    @(posedge clk_i) disable iff (!resetn_i)
    (en_chg && !sw_rst && !q.rst_busy) |=> q.restart ##1 an_restart_o)
    else $error("enable change did not restart negotiation");

  a_fx_en_off: assert property ( // see [RULE_12]
    @(posedge clk_i) disable iff (!resetn_i)
    ($past(fiber_mode_i) == MODE_100FX) |-> !autoneg_en_o)
    else $error("negotiation enabled in 100FX mode");

  a_strap_loads_en: assert property ( // see [RULE_13]
    @(posedge clk_i) disable iff (!resetn_i)
    (!q.init_done && q.init_cnt == STRAP_WAIT)
    |=> (q.an_en == $past(q.strap_s[1])))
    else $error("negotiation enable missed the strap");

  a_wake_soft_reset: assert property ( // see [RULE_14]
    @(posedge clk_i) disable iff (!resetn_i)
    pd_wake |=> (fiber_reset_o && q.restart))
    else $error("wake from power down did not reset");

  a_restart_bit_runs: assert property ( // see [RULE_15]
    @(posedge clk_i) disable iff (!resetn_i)
    (fc_wr && wdata_i[FC_RESTART] && !sw_rst && !q.rst_busy)
    |=> ##1 an_restart_o)
    else $error("restart bit did not restart negotiation");

  a_duplex_only_restart: assert property ( // see [RULE_16]
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(duplex_full_o) |-> an_restart_o)
    else $error("duplex changed outside a restart");

  a_unsupported_zero: assert property ( // see [RULE_17]
    @(posedge clk_i) disable iff (!resetn_i)
    fc_rd |=> (rdata_o[FC_ISOLATE] == 1'b0 && rdata_o[FC_COLTEST] == 1'b0))
    else $error("isolate or collision test read nonzero");

endmodule : pfc_regs

// ---- inc/pfc_pkg.sv ----
// constants shared by the fiber control register bank
package pfc_pkg;

  // register numbers on the management port
  localparam logic [4:0] REG_FIBER_CTRL = 5'h00;
  localparam logic [4:0] REG_RXERR      = 5'h15;
  localparam logic [4:0] REG_PAGE       = 5'h16;
  localparam logic [4:0] REG_GINT       = 5'h17;
  localparam logic [4:0] REG_IRQ_STAT   = 5'h1d;
  localparam logic [4:0] REG_IRQ_CLR    = 5'h1e;
  localparam logic [4:0] REG_IRQ_EN     = 5'h1f;

  // page numbers
  localparam logic [7:0] PAGE_COPPER = 8'h00;
  localparam logic [7:0] PAGE_FIBER  = 8'h01;

  // fiber control field positions
  localparam int unsigned FC_RESET   = 15;
  localparam int unsigned FC_LOOP    = 14;
  localparam int unsigned FC_SPD_LSB = 13;
  localparam int unsigned FC_AN_EN   = 12;
  localparam int unsigned FC_PDOWN   = 11;
  localparam int unsigned FC_ISOLATE = 10;
  localparam int unsigned FC_RESTART = 9;
  localparam int unsigned FC_DUPLEX  = 8;
  localparam int unsigned FC_COLTEST = 7;
  localparam int unsigned FC_SPD_MSB = 6;

  // fiber mode field encodings
  localparam logic [1:0] MODE_100FX = 2'h0;
  localparam logic [1:0] MODE_1000X = 2'h1;
  localparam logic [1:0] MODE_NEG   = 2'h2;
  localparam logic [1:0] MODE_SW    = 2'h3;

  // speed codes
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_100  = 2'h1;

  // values after hardware reset, and the counter ceiling
  localparam logic [7:0]  PAGE_RST   = 8'h00;
  localparam logic [1:0]  SPD_RST    = 2'h2;
  localparam logic        DUPLEX_RST = 1'h1;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;

  // interrupt event bits
  localparam int unsigned EV_W       = 4;
  localparam int unsigned EV_RXERR   = 0;
  localparam int unsigned EV_SAT     = 1;
  localparam int unsigned EV_ANRST   = 2;
  localparam int unsigned EV_RSTDONE = 3;

  // cycle counts
  localparam logic [3:0] FRST_CYCLES = 4'h8;
  localparam logic [1:0] STRAP_WAIT  = 2'h2;

endpackage : pfc_pkg

// ---- inc/pfc_ev_if.sv ----
// signals between the register bank and its counter and interrupt helpers
`timescale 1ns/1ps
interface pfc_ev_if;
  import pfc_pkg::*;
  logic            false_carrier;
  logic            symbol_err;
  logic            cnt_clr;
  logic [15:0]     cnt;
  logic            cnt_inc;
  logic            cnt_sat;
  logic [EV_W-1:0] ev;
  logic            irq_clr_wr;
  logic            irq_en_wr;
  logic [EV_W-1:0] irq_wdata;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_enable;
  logic            irq;

  modport cnt_side (input false_carrier, symbol_err, cnt_clr,
                    output cnt, cnt_inc, cnt_sat);
  modport irq_side (input ev, irq_clr_wr, irq_en_wr, irq_wdata,
                    output irq_status, irq_enable, irq);
  modport top_side (output false_carrier, symbol_err, cnt_clr, ev,
                    irq_clr_wr, irq_en_wr, irq_wdata,
                    input cnt, cnt_inc, cnt_sat, irq_status,
                    irq_enable, irq);
endinterface : pfc_ev_if

// ---- rtl/pfc_rxerr_cnt.sv ----
// saturating receive error counter, cleared by a read
`timescale 1ns/1ps
module pfc_rxerr_cnt
  import pfc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  pfc_ev_if.cnt_side ev
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        inc;
    logic        sat;
  } pfc_cnt_s;

  pfc_cnt_s q;
  pfc_cnt_s d;

  // both error kinds may land together, so add two
  always_comb begin
    logic [16:0] sum;
    logic [15:0] base;
    sum    = '0;
    base   = ev.cnt_clr ? CNT_RST : q.cnt;         // see [RULE_03]
    sum    = {1'b0, base} + {16'h0000, ev.false_carrier}
           + {16'h0000, ev.symbol_err};            // see [RULE_02]
    d      = q;
    d.cnt  = sum[16] ? CNT_MAX : sum[15:0];        // see [RULE_01]
    d.inc  = ev.false_carrier | ev.symbol_err;
    d.sat  = (d.cnt == CNT_MAX) && (q.cnt != CNT_MAX);
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{cnt: CNT_RST, inc: 1'b0, sat: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ev.cnt     = q.cnt;
  assign ev.cnt_inc = q.inc;
  assign ev.cnt_sat = q.sat;

  a_cnt_pegs_max: assert property ( // see [RULE_01]
    @(posedge clk_i) disable iff (!resetn_i)
    (q.cnt == CNT_MAX && !ev.cnt_clr) |=> (q.cnt == CNT_MAX))
    else $error("error counter rolled over");

  a_cnt_counts_one: assert property ( // see [RULE_02]
    @(posedge clk_i) disable iff (!resetn_i)
    (!ev.cnt_clr && q.cnt < 16'hfffe && (ev.false_carrier ^ ev.symbol_err))
    |=> (q.cnt == $past(q.cnt) + 16'h0001))
    else $error("error counter missed an event");

  a_cnt_read_clear: assert property ( // see [RULE_03]
    @(posedge clk_i) disable iff (!resetn_i)
    (ev.cnt_clr && !ev.false_carrier && !ev.symbol_err)
    |=> (q.cnt == CNT_RST))
    else $error("error counter not cleared by read");

endmodule : pfc_rxerr_cnt

// ---- rtl/pfc_irq.sv ----
// sticky interrupt status, enable mask and level interrupt
`timescale 1ns/1ps
module pfc_irq
  import pfc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  pfc_ev_if.irq_side ev
);

  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] enable;
    logic            irq;
  } pfc_irq_s;

  pfc_irq_s q;
  pfc_irq_s d;

  // a new event wins over a clear in the same cycle
  always_comb begin
    logic [EV_W-1:0] clr;
    clr      = ev.irq_clr_wr ? ev.irq_wdata : '0;
    d        = q;
    d.status = (q.status & ~clr) | ev.ev;
    if (ev.irq_en_wr) begin
      d.enable = ev.irq_wdata;
    end
    d.irq    = |(q.status & q.enable);
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ev.irq_status = q.status;
  assign ev.irq_enable = q.enable;
  assign ev.irq        = q.irq;

endmodule : pfc_irq

// ---- dv/pfc_mgmt_model.sv ----
// management controller model driving the register port
`timescale 1ns/1ps
module pfc_mgmt_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [4:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  // idle bus at time zero
  initial begin
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // one-cycle write; data inverted after so stale values never match
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd_reg
endmodule : pfc_mgmt_model

// ---- dv/tb_top.sv ----
// self-checking bench for the fiber control register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("mismatch t=%0t got=%h exp=%h", $time, (got), \
  (exp)); end end
module tb_top;
  import pfc_pkg::*;
  localparam logic [15:0] B_AN  = 16'h0001 << FC_AN_EN;
  localparam logic [15:0] B_DP  = 16'h0001 << FC_DUPLEX;
  localparam logic [15:0] B_LP  = 16'h0001 << FC_LOOP;
  localparam logic [15:0] B_RS  = 16'h0001 << FC_RESTART;
  localparam logic [15:0] B_RST = 16'h0001 << FC_RESET;
  localparam logic [15:0] B_PD  = 16'h0001 << FC_PDOWN;
  localparam logic [15:0] B_UNS = (16'h0001 << FC_ISOLATE) |
                                  (16'h0001 << FC_COLTEST);
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        false_carrier_i = 1'b0;
  logic        symbol_err_i = 1'b0;
  logic [1:0]  fiber_mode_i = MODE_1000X;
  logic        neg_speed_1000_i = 1'b0;
  logic        strap_autoneg_default_i = 1'b1;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, rd_v, w;
  logic        wr, rd, fcv, sev, neg;
  logic        fiber_reset_o, loopback_o, loop_rate_1000_o, link_break_o;
  logic        autoneg_en_o, an_restart_o, power_down_o, duplex_full_o;
  logic        irq_o;
  logic [1:0]  speed_o, m, sw;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          seed, exp_cnt, n_rst, n_an;

  always #5 clk_i = ~clk_i;

  pfc_mgmt_model i_pfc_mgmt_model (.clk_i(clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  pfc_regs i_pfc_regs (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .false_carrier_i(false_carrier_i), .symbol_err_i(symbol_err_i),
    .fiber_mode_i(fiber_mode_i), .neg_speed_1000_i(neg_speed_1000_i),
    .strap_autoneg_default_i(strap_autoneg_default_i),
    .fiber_reset_o(fiber_reset_o), .loopback_o(loopback_o),
    .loop_rate_1000_o(loop_rate_1000_o), .link_break_o(link_break_o),
    .speed_o(speed_o), .autoneg_en_o(autoneg_en_o),
    .an_restart_o(an_restart_o), .power_down_o(power_down_o),
    .duplex_full_o(duplex_full_o), .irq_o(irq_o));

  // expected speed code for a fiber mode
  function automatic logic [1:0] exp_speed(logic [1:0] md, logic ng,
                                           logic [1:0] s);
    case (md)
      MODE_100FX: return SPD_100;
      MODE_1000X: return SPD_1000;
      MODE_NEG:   return ng ? SPD_1000 : SPD_100;
      default:    return s;
    endcase
  endfunction : exp_speed

  // fiber control word from flag bits and a speed code
  function automatic logic [15:0] fc(logic [15:0] f, logic [1:0] s);
    return f | (16'(s[0]) << FC_SPD_LSB) | (16'(s[1]) << FC_SPD_MSB);
  endfunction : fc

  task automatic wr_r(input logic [4:0] a, input logic [15:0] d);
    i_pfc_mgmt_model.wr_reg(a, d);
  endtask : wr_r

  task automatic rd_r(input logic [4:0] a);
    i_pfc_mgmt_model.rd_reg(a, rd_v);
  endtask : rd_r

  // counts reset-busy and restart cycles over a fixed window
  task automatic watch(input int n);
    n_rst = 0;
    n_an  = 0;
    repeat (n) begin
      #1;
      n_rst += int'(fiber_reset_o === 1'b1);
      n_an  += int'(an_restart_o === 1'b1);
      @(posedge clk_i);
    end
  endtask : watch

  // bounded wait for a restart pulse; a miss ends the run
  task automatic wait_restart;
    int i;
    for (i = 0; i < 20; i++) begin
      #1;
      if (an_restart_o === 1'b1) break;
      @(posedge clk_i);
    end
    if (i == 20) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
    end
  endtask : wait_restart

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // main sequence; strap high and 1000X mode during hard reset
  initial begin
    seed = 88;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    watch(12);
    `CHK(n_an, 1)
    `CHK(autoneg_en_o, 1'b1)
    `CHK(duplex_full_o, DUPLEX_RST)
    rd_r(REG_PAGE);
    `CHK(rd_v, 16'h0000)
    rd_r(REG_GINT);
    `CHK(rd_v, 16'h0000)
    done("reset");
    repeat (4) begin
      w = 16'($random(seed));
      wr_r(REG_PAGE, w);
      rd_r(REG_PAGE);
      `CHK(rd_v, {8'h00, w[7:0]})
    end
    wr_r(REG_PAGE, 16'(PAGE_COPPER));
    done("page");
    // random error bursts, both kinds at once count twice
    exp_cnt = 0;
    repeat (200) begin
      @(posedge clk_i);
      fcv = 1'($random(seed));
      sev = 1'($random(seed));
      false_carrier_i <= fcv;
      symbol_err_i    <= sev;
      exp_cnt += fcv + sev;
    end
    @(posedge clk_i);
    false_carrier_i <= 1'b0;
    symbol_err_i    <= 1'b0;
    rd_r(REG_RXERR);
    `CHK(rd_v, 16'(exp_cnt))
    rd_r(REG_RXERR);
    `CHK(rd_v, CNT_RST)
    @(posedge clk_i);
    false_carrier_i <= 1'b1;
    symbol_err_i    <= 1'b1;
    repeat (32800) @(posedge clk_i);
    false_carrier_i <= 1'b0;
    symbol_err_i    <= 1'b0;
    rd_r(REG_RXERR);
    `CHK(rd_v, CNT_MAX)
    rd_r(REG_RXERR);
    `CHK(rd_v, CNT_RST)
    done("counter");
    // interrupt raised, cleared, then masked
    wr_r(REG_IRQ_EN, 16'h0001);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b1)
    rd_r(REG_GINT);
    `CHK(rd_v, 16'h0001)
    wr_r(REG_IRQ_CLR, 16'h000f);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b0)
    rd_r(REG_GINT);
    `CHK(rd_v, 16'h0000)
    wr_r(REG_IRQ_EN, 16'h0000);
    symbol_err_i <= 1'b1;
    @(posedge clk_i);
    symbol_err_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b0)
    rd_r(REG_IRQ_STAT);
    `CHK(rd_v[EV_RXERR], 1'b1)
    done("irq");
    // every fiber mode with loopback on and a random speed code
    wr_r(REG_PAGE, 16'(PAGE_FIBER));
    for (int i = 0; i < 4; i++) begin
      m   = i[1:0];
      neg = 1'($random(seed));
      sw  = 2'($random(seed));
      if (sw == 2'h3) sw = SPD_100;
      @(posedge clk_i);
      fiber_mode_i     <= m;
      neg_speed_1000_i <= neg;
      wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP | B_LP, sw));
      repeat (3) @(posedge clk_i);
      sw = exp_speed(m, neg, sw);
      #1 `CHK(speed_o, sw)
      `CHK(loopback_o, 1'b1)
      `CHK(link_break_o, 1'b1)
      if (m != MODE_NEG && m != MODE_SW)
        `CHK(loop_rate_1000_o, m == MODE_1000X)
      rd_r(REG_FIBER_CTRL);
      `CHK({rd_v[FC_SPD_MSB], rd_v[FC_SPD_LSB]}, sw)
    end
    @(posedge clk_i);
    fiber_mode_i <= MODE_1000X;
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP, 2'h0));
    done("speed and loopback");
    // duplex waits for a restart before it applies
    wr_r(REG_FIBER_CTRL, fc(B_AN, 2'h0));
    repeat (4) @(posedge clk_i);
    #1 `CHK(duplex_full_o, 1'b1)
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_RS, 2'h0));
    wait_restart();
    `CHK(duplex_full_o, 1'b0)
    wr_r(REG_FIBER_CTRL, fc(B_DP, 2'h0));
    wait_restart();
    `CHK(autoneg_en_o, 1'b0)
    `CHK(duplex_full_o, 1'b1)
    @(posedge clk_i);
    fiber_mode_i <= MODE_100FX;
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP, 2'h0));
    watch(8);
    `CHK(n_an, 0)
    `CHK(autoneg_en_o, 1'b0)
    fiber_mode_i <= MODE_1000X;
    done("negotiation");
    // soft reset keeps page and enable
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP | B_RST, 2'h0));
    watch(14);
    `CHK(n_rst, int'(FRST_CYCLES))
    `CHK(n_an, 1)
    rd_r(REG_FIBER_CTRL);
    `CHK(rd_v[FC_RESET], 1'b0)
    rd_r(REG_PAGE);
    `CHK(rd_v, 16'(PAGE_FIBER))
    `CHK(autoneg_en_o, 1'b1)
    // wake from power down acts as soft reset plus restart
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP | B_PD, 2'h0));
    repeat (2) @(posedge clk_i);
    #1 `CHK(power_down_o, 1'b1)
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP, 2'h0));
    watch(14);
    `CHK(n_an, 1)
    `CHK(n_rst, int'(FRST_CYCLES))
    wr_r(REG_FIBER_CTRL, fc(B_AN | B_DP | B_UNS, 2'h0));
    rd_r(REG_FIBER_CTRL);
    `CHK(rd_v & B_UNS, 16'h0000)
    rd_r(5'h05);
    `CHK(rd_v, 16'h0000)
    done("reset and power");
    summarize();
  end
endmodule : tb_top
